// ### spuart_serial_port.sv
// Serial port with extended receive status, silence timer and threshold
//
// Added by the designer: the placing of the registers and strobed register access.
`include "spuart_params.svh"

// Notes on behaviour
// - Twelve line speeds from 200 to 115200 bps, 115200 after reset.
// - Character width five to eight bits, eight after reset.
// - Parity odd, even, mark, space or none; none after reset.
// - Five-bit characters stop 1 or 1.5; wider ones stop 1 or 2.
// - Normal mode or extended receive mode; normal after reset.
// - Extended mode returns each character with an error byte and its silence count.
// - Error bit 0 marks an invalid character; bits 1 and 2 unused.
// - Error bit 3 marks a break: line low from the start bit through the stop bit.
// - Error bit 4 marks a low first stop bit.
// - Error bit 5 marks a parity mismatch.
// - Error bit 6 marks lost characters, on the first read after.
// - Error bit 7 marks a character stored over an unread one.
// - Each character carries a 16-bit silence count in 10 us units.
// - The silence count saturates at 65535.
// - Silence restarts at character end, reconfiguration or tx end.
// - Current silence since the last character is readable.
// - Threshold flag at 1, 4, 8 or 14 stored bytes; 8 after reset.
module spuart_serial_port
    import spuart_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_txd_oe,
    output logic o_rx_thresh
);

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [15:0] baud_div(input logic [3:0] sel);
        unique case (sel)
            4'h0: baud_div = 16'(`SPUART_OVS_HZ / 200);
            4'h1: baud_div = 16'(`SPUART_OVS_HZ / 300);
            4'h2: baud_div = 16'(`SPUART_OVS_HZ / 600);
            4'h3: baud_div = 16'(`SPUART_OVS_HZ / 1200);
            4'h4: baud_div = 16'(`SPUART_OVS_HZ / 1800);
            4'h5: baud_div = 16'(`SPUART_OVS_HZ / 2400);
            4'h6: baud_div = 16'(`SPUART_OVS_HZ / 4800);
            4'h7: baud_div = 16'(`SPUART_OVS_HZ / 9600);
            4'h8: baud_div = 16'(`SPUART_OVS_HZ / 19200);
            4'h9: baud_div = 16'(`SPUART_OVS_HZ / 38400);
            4'ha: baud_div = 16'(`SPUART_OVS_HZ / 57600);
            default: baud_div = 16'(`SPUART_OVS_HZ / 115200);
        endcase
    endfunction : baud_div

    function automatic logic par_calc(input logic [7:0] d,
                                      input logic [2:0] sel);
        unique case (sel)
            PAR_ODD: par_calc = ~^d;
            PAR_EVEN: par_calc = ^d;
            PAR_MARK: par_calc = 1'b1;
            default: par_calc = 1'b0;
        endcase
    endfunction : par_calc

    // ------------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------------
    logic [`SPUART_CFG_W-1:0] cfg_reg;
    logic cfg_wr;
    logic [3:0] baud_sel;
    logic [1:0] dbits_sel;
    logic [2:0] par_sel;
    logic stop_sel;
    logic ext_mode;
    logic r422_mode;
    logic [1:0] thr_sel;
    logic par_en;
    logic [2:0] nb_m1;
    logic [7:0] data_mask;
    logic [4:0] thr_level;

    assign cfg_wr = i_wr && (i_addr == `SPUART_OFF_CFG);
    assign baud_sel = cfg_reg[`SPUART_CFG_BAUD_LSB +: 4];
    assign dbits_sel = cfg_reg[`SPUART_CFG_DBITS_LSB +: 2];
    assign par_sel = cfg_reg[`SPUART_CFG_PAR_LSB +: 3];
    assign stop_sel = cfg_reg[`SPUART_CFG_STOP_BIT];
    assign ext_mode = cfg_reg[`SPUART_CFG_EXT_BIT];
    assign r422_mode = cfg_reg[`SPUART_CFG_R422_BIT];
    assign thr_sel = cfg_reg[`SPUART_CFG_THR_LSB +: 2];
    assign par_en = (par_sel == PAR_ODD) || (par_sel == PAR_EVEN) ||
                    (par_sel == PAR_MARK) || (par_sel == PAR_SPACE);
    assign nb_m1 = 3'({1'b0, dbits_sel} + 3'h4);
    assign data_mask = 8'(8'hff >> (2'h3 - dbits_sel));

    always_comb begin
        unique case (thr_sel)
            2'h0: thr_level = 5'h01;
            2'h1: thr_level = 5'h04;
            2'h2: thr_level = 5'h08;
            default: thr_level = 5'h0e;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            cfg_reg <= `SPUART_CFG_RST;
        end else if (cfg_wr) begin
            cfg_reg <= i_wdata[`SPUART_CFG_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Oversampling tick, 16 per bit
    // ------------------------------------------------------------------
    logic [15:0] div_cnt_reg;
    logic [15:0] div_m1;
    logic tick;

    assign div_m1 = 16'(baud_div(baud_sel) - 16'h1);
    assign tick = (div_cnt_reg == div_m1);

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr || tick) begin
            div_cnt_reg <= 16'h0;
        end else begin
            div_cnt_reg <= 16'(div_cnt_reg + 16'h1);
        end
    end

    // ------------------------------------------------------------------
    // Silence timer
    // ------------------------------------------------------------------
    logic [11:0] sil_pre_reg;
    logic [15:0] sil_reg;
    logic rx_end;
    logic tx_done;
    logic sil_restart;

    assign sil_restart = rx_end || cfg_wr || tx_done;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || sil_restart) begin
            sil_pre_reg <= 12'h0;
            sil_reg <= 16'h0;
        end else if (sil_pre_reg == 12'(`SPUART_SIL_CYC - 1)) begin
            sil_pre_reg <= 12'h0;
            if (sil_reg != `SPUART_SIL_MAX) begin
                sil_reg <= 16'(sil_reg + 16'h1);
            end
        end else begin
            sil_pre_reg <= 12'(sil_pre_reg + 12'h1);
        end
    end

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    logic rx_meta_reg;
    logic rx_sync_reg;
    spuart_rx_t rx_st_reg;
    logic [3:0] rx_tc_reg;
    logic [2:0] rx_bit_reg;
    logic [7:0] rx_sh_reg;
    logic rx_par_reg;
    logic rx_low_reg;
    logic [15:0] rx_ts_reg;
    logic rx_mid;
    logic [7:0] rx_err;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= i_rxd;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    assign rx_mid = tick && (rx_tc_reg == 4'hf);
    assign rx_end = (rx_st_reg == RX_STOP) && rx_mid;

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr || (rx_st_reg == RX_IDLE)) begin
            rx_tc_reg <= 4'h0;
        end else if (tick) begin
            if ((rx_st_reg == RX_START) && (rx_tc_reg == 4'h7)) begin
                rx_tc_reg <= 4'h0;
            end else begin
                rx_tc_reg <= 4'(rx_tc_reg + 4'h1);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr) begin
            rx_st_reg <= RX_IDLE;
            rx_bit_reg <= 3'h0;
            rx_sh_reg <= 8'h0;
            rx_par_reg <= 1'b0;
            rx_low_reg <= 1'b0;
            rx_ts_reg <= 16'h0;
        end else begin
            unique case (rx_st_reg)
                RX_IDLE: begin
                    if (tick && !rx_sync_reg) begin
                        rx_st_reg <= RX_START;
                        rx_ts_reg <= sil_reg;
                    end
                end
                RX_START: begin
                    if (tick && (rx_tc_reg == 4'h7)) begin
                        rx_st_reg <= rx_sync_reg ? RX_IDLE : RX_DATA;
                        rx_bit_reg <= 3'h0;
                        rx_sh_reg <= 8'h0;
                        rx_low_reg <= 1'b1;
                    end
                end
                RX_DATA: begin
                    if (rx_mid) begin
                        rx_sh_reg[rx_bit_reg] <= rx_sync_reg;
                        if (rx_sync_reg) begin
                            rx_low_reg <= 1'b0;
                        end
                        if (rx_bit_reg == nb_m1) begin
                            rx_st_reg <= par_en ? RX_PAR : RX_STOP;
                        end else begin
                            rx_bit_reg <= 3'(rx_bit_reg + 3'h1);
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_mid) begin
                        rx_par_reg <= rx_sync_reg;
                        if (rx_sync_reg) begin
                            rx_low_reg <= 1'b0;
                        end
                        rx_st_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_mid) begin
                        rx_st_reg <= rx_sync_reg ? RX_IDLE : RX_BRK;
                    end
                end
                RX_BRK: begin
                    if (rx_sync_reg) begin
                        rx_st_reg <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------------
    logic [31:0] fifo_mem [`SPUART_FIFO_DEPTH];
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] cnt_reg;
    logic ovr_reg;
    logic fifo_full;
    logic pop;
    logic overwrite;
    logic [3:0] wr_idx;
    logic [31:0] rx_head;
    logic [7:0] rd_err;

    assign fifo_full = (cnt_reg == 5'(`SPUART_FIFO_DEPTH));
    assign pop = i_rd && (i_addr == `SPUART_OFF_RXDATA) && (cnt_reg != 5'h0);
    assign overwrite = rx_end && fifo_full && !pop;
    assign wr_idx = overwrite ? 4'(wr_ptr_reg - 4'h1) : wr_ptr_reg;

    always_comb begin
        rx_err = 8'h0;
        rx_err[`SPUART_ERR_BREAK] = rx_low_reg && !rx_sync_reg;
        rx_err[`SPUART_ERR_FRAME] = !rx_sync_reg;
        rx_err[`SPUART_ERR_PARITY] = par_en &&
            (rx_par_reg != par_calc(rx_sh_reg, par_sel));
        rx_err[`SPUART_ERR_OVERWRITE] = overwrite;
        rx_err[`SPUART_ERR_INVALID] = |rx_err[7:3];
    end

    always_ff @(posedge i_sys_clk) begin
        if (rx_end) begin
            fifo_mem[wr_idx] <= {rx_ts_reg, rx_err, rx_sh_reg};
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            cnt_reg <= 5'h0;
        end else begin
            if (rx_end && !overwrite) begin
                wr_ptr_reg <= 4'(wr_ptr_reg + 4'h1);
            end
            if (pop) begin
                rd_ptr_reg <= 4'(rd_ptr_reg + 4'h1);
            end
            if ((rx_end && !overwrite) && !pop) begin
                cnt_reg <= 5'(cnt_reg + 5'h1);
            end else if (pop && !rx_end) begin
                cnt_reg <= 5'(cnt_reg - 5'h1);
            end
        end
    end

    // Lost-data flag: a new loss wins over the read that clears it
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr) begin
            ovr_reg <= 1'b0;
        end else begin
            ovr_reg <= (ovr_reg && !pop) || overwrite;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_rx_thresh <= 1'b0;
        end else begin
            o_rx_thresh <= (cnt_reg >= thr_level);
        end
    end

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    logic [7:0] tx_hold_reg;
    logic tx_hold_vld_reg;
    spuart_tx_t tx_st_reg;
    logic [5:0] tx_tc_reg;
    logic [2:0] tx_bit_reg;
    logic [7:0] tx_sh_reg;
    logic tx_par_reg;
    logic tx_wr;
    logic tx_bit_end;
    logic [5:0] stop_m1;

    assign tx_wr = i_wr && (i_addr == `SPUART_OFF_TXDATA);
    assign tx_bit_end = tick && (tx_tc_reg[3:0] == 4'hf);
    assign stop_m1 = !stop_sel ? 6'h0f :
                     (dbits_sel == 2'h0) ? 6'h17 : 6'h1f;
    assign tx_done = (tx_st_reg == TX_STOP) && tick && (tx_tc_reg == stop_m1);

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr) begin
            tx_hold_reg <= 8'h0;
            tx_hold_vld_reg <= 1'b0;
        end else if (tx_wr && !tx_hold_vld_reg) begin
            tx_hold_reg <= i_wdata[7:0] & data_mask;
            tx_hold_vld_reg <= 1'b1;
        end else if (tx_st_reg == TX_IDLE) begin
            tx_hold_vld_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || cfg_wr || (tx_st_reg == TX_IDLE) ||
            (tx_bit_end && (tx_st_reg != TX_STOP)) || tx_done) begin
            tx_tc_reg <= 6'h0;
        end else if (tick) begin
            tx_tc_reg <= 6'(tx_tc_reg + 6'h1);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            tx_st_reg <= TX_IDLE;
            tx_bit_reg <= 3'h0;
            tx_sh_reg <= 8'h0;
            tx_par_reg <= 1'b0;
            o_txd <= 1'b1;
            o_txd_oe <= 1'b0;
        end else if (cfg_wr) begin
            tx_st_reg <= TX_IDLE;
            o_txd <= 1'b1;
            o_txd_oe <= i_wdata[`SPUART_CFG_R422_BIT];
        end else begin
            unique case (tx_st_reg)
                TX_IDLE: begin
                    o_txd <= 1'b1;
                    o_txd_oe <= r422_mode || tx_hold_vld_reg;
                    if (tx_hold_vld_reg) begin
                        tx_st_reg <= TX_START;
                        tx_sh_reg <= tx_hold_reg;
                        tx_par_reg <= par_calc(tx_hold_reg, par_sel);
                        tx_bit_reg <= 3'h0;
                        o_txd <= 1'b0;
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_st_reg <= TX_DATA;
                        o_txd <= tx_sh_reg[0];
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        if (tx_bit_reg == nb_m1) begin
                            tx_st_reg <= par_en ? TX_PAR : TX_STOP;
                            o_txd <= par_en ? tx_par_reg : 1'b1;
                        end else begin
                            tx_bit_reg <= 3'(tx_bit_reg + 3'h1);
                            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
                            o_txd <= tx_sh_reg[1];
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_bit_end) begin
                        tx_st_reg <= TX_STOP;
                        o_txd <= 1'b1;
                    end
                end
                TX_STOP: begin
                    if (tx_done) begin
                        tx_st_reg <= TX_IDLE;
                        o_txd_oe <= r422_mode;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    assign rx_head = fifo_mem[rd_ptr_reg];

    always_comb begin
        rd_err = rx_head[15:8];
        rd_err[`SPUART_ERR_OVERRUN] = ovr_reg;
        rd_err[`SPUART_ERR_INVALID] = rx_head[8] || ovr_reg;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst || !i_rd) begin
            o_rdata <= 32'h0;
        end else begin
            unique case (i_addr)
                `SPUART_OFF_CFG: begin
                    o_rdata <= {18'h0, cfg_reg};
                end
                `SPUART_OFF_RXDATA: begin
                    if (cnt_reg == 5'h0) begin
                        o_rdata <= 32'h0;
                    end else if (ext_mode) begin
                        o_rdata <= {rx_head[31:16], rd_err,
                                    rx_head[7:0]};
                    end else begin
                        o_rdata <= {24'h0, rx_head[7:0]};
                    end
                end
                `SPUART_OFF_STATUS: begin
                    o_rdata <= {24'h0, tx_hold_vld_reg,
                                (tx_st_reg != TX_IDLE), o_rx_thresh,
                                cnt_reg};
                end
                `SPUART_OFF_SILENCE: begin
                    o_rdata <= {16'h0, sil_reg};
                end
                default: begin
                    o_rdata <= 32'h0;
                end
            endcase
        end
    end

endmodule : spuart_serial_port

// ### spuart_params.svh
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef SPUART_PARAMS_SVH
`define SPUART_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define SPUART_OFF_CFG 8'h00
`define SPUART_OFF_TXDATA 8'h04
`define SPUART_OFF_RXDATA 8'h08
`define SPUART_OFF_STATUS 8'h0c
`define SPUART_OFF_SILENCE 8'h10

// ----------------------------------------------------------------------
// Configuration fields and reset value
// ----------------------------------------------------------------------
`define SPUART_CFG_W 14
`define SPUART_CFG_BAUD_LSB 0
`define SPUART_CFG_DBITS_LSB 4
`define SPUART_CFG_PAR_LSB 6
`define SPUART_CFG_STOP_BIT 9
`define SPUART_CFG_EXT_BIT 10
`define SPUART_CFG_R422_BIT 11
`define SPUART_CFG_THR_LSB 12
`define SPUART_CFG_RST 14'h203b

// ----------------------------------------------------------------------
// Error byte bit positions
// ----------------------------------------------------------------------
`define SPUART_ERR_INVALID 0
`define SPUART_ERR_BREAK 3
`define SPUART_ERR_FRAME 4
`define SPUART_ERR_PARITY 5
`define SPUART_ERR_OVERRUN 6
`define SPUART_ERR_OVERWRITE 7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPUART_CLK_HZ 200000000
`define SPUART_CLK_NS 5
`define SPUART_OVS 16
`define SPUART_OVS_HZ (`SPUART_CLK_HZ / `SPUART_OVS)
`define SPUART_SIL_UNIT_NS 10000
`define SPUART_SIL_CYC (`SPUART_SIL_UNIT_NS / `SPUART_CLK_NS)
`define SPUART_SIL_MAX 16'hffff
`define SPUART_FIFO_DEPTH 16

`endif

// ### spuart_pkg.sv
// Types shared by the serial port design
package spuart_pkg;

    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_START = 6'h02,
        RX_DATA = 6'h04,
        RX_PAR = 6'h08,
        RX_STOP = 6'h10,
        RX_BRK = 6'h20
    } spuart_rx_t;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PAR = 5'h08,
        TX_STOP = 5'h10
    } spuart_tx_t;

    typedef enum logic [2:0] {
        PAR_NONE = 3'h0,
        PAR_ODD = 3'h1,
        PAR_EVEN = 3'h2,
        PAR_MARK = 3'h3,
        PAR_SPACE = 3'h4
    } spuart_par_t;

endpackage : spuart_pkg

// ### spuart_checker.sv
// Assertions on the serial port pins and register bus
module spuart_checker (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_rxd,
    input wire logic o_txd,
    input wire logic o_txd_oe,
    input wire logic o_rx_thresh
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    a_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not idle");
    a_unmapped_zero: assert property (i_rd && !(i_addr inside
        {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}) |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_err_unused: assert property (i_rd && i_addr == 8'h08 |=>
        o_rdata[10:9] == 2'h0) else $error("unused error bits set");
    a_err_invalid: assert property (i_rd && i_addr == 8'h08 |=>
        o_rdata[8] == (|o_rdata[15:11])) else $error("invalid bit wrong");
    a_txd_idle: assert property (!o_txd_oe |-> o_txd)
        else $error("line low while released");
    a_start_driven: assert property ($fell(o_txd) |-> o_txd_oe)
        else $error("start bit without driver");
    a_stop_high: assert property ($fell(o_txd_oe) && !$past(i_wr) &&
        !$past(i_wr, 2) |-> $past(o_txd)) else $error("release not on stop");
    a_cfg_flush: assert property (i_wr && i_addr == 8'h00 |->
        ##2 !o_rx_thresh) else $error("threshold kept after flush");
endmodule : spuart_checker

bind spuart_serial_port spuart_checker u_chk (.i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd),
    .o_txd_oe(o_txd_oe), .o_rx_thresh(o_rx_thresh));

// ### spuart_remote.sv
// Behavioural remote station on the serial line
module spuart_remote #(
    parameter int BIT_CYC = 1728
) (
    input wire logic i_sys_clk,
    input wire logic i_line,
    output logic o_rxd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_byte = 8'h00;
    logic got_stop = 1'b0;
    int got_cnt = 0;
    initial o_rxd = 1'b1;
    // Start, data LSB first, parity, stop, then idle high
    task automatic send(input logic [10:0] bits);
        for (int i = 0; i < 11; i++) begin
            o_rxd <= bits[i];
            repeat (BIT_CYC) @(posedge i_sys_clk);
        end
        o_rxd <= 1'b1;
    endtask : send
    // Samples the eight data bits and the stop bit at their middles
    always @(negedge i_line) begin
        repeat (BIT_CYC / 2) @(posedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge i_sys_clk);
            got_byte[i] = i_line;
        end
        repeat (BIT_CYC) @(posedge i_sys_clk);
        got_stop = i_line;
        got_cnt++;
    end
endmodule : spuart_remote

// ### test_serial_port_rx_status_uart.sv
// Self-checking bench for the serial port
`include "spuart_params.svh"
module test_serial_port_rx_status_uart;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // Bench
    // ----------
    logic sys_clk;
    logic sys_nrst;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic rxd;
    logic txd;
    logic txd_oe;
    logic rx_thresh;
    logic line;
    logic [31:0] d;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Failsafe bias holds the released line high
    assign line = txd_oe ? txd : 1'b1;
    spuart_serial_port u_dut (.i_sys_clk(sys_clk), .i_nrst(sys_nrst),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_rxd(rxd), .o_txd(txd), .o_txd_oe(txd_oe),
        .o_rx_thresh(rx_thresh));
    spuart_remote u_remote (.i_sys_clk(sys_clk), .i_line(line),
        .o_rxd(rxd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge sys_clk);
    endtask : bus_rd
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // Defaults: 115200, 8 bits, no parity, 1 stop, normal, RS-485, 8 bytes
    task automatic test_reset();
        bus_rd(`SPUART_OFF_CFG);
        check(d, 32'h0000_203b);
        bus_rd(`SPUART_OFF_STATUS);
        check(d, 32'h0);
        bus_rd(8'h14);
        check(d, 32'h0);
        check({txd_oe, txd}, 32'h1);
        $display("reset test done");
    endtask : test_reset
    task automatic test_tx();
        int c0;
        c0 = u_remote.got_cnt;
        bus_wr(`SPUART_OFF_TXDATA, 32'h0000_00a5);
        repeat (100) @(posedge sys_clk);
        check(txd_oe, 1'b1);
        while (u_remote.got_cnt == c0) @(posedge sys_clk);
        check({u_remote.got_stop, u_remote.got_byte}, 32'h1a5);
        while (txd_oe === 1'b1) @(posedge sys_clk);
        repeat (4100) @(posedge sys_clk);
        bus_rd(`SPUART_OFF_SILENCE);
        check(d, 32'h2);
        $display("tx test done");
    endtask : test_tx
    // Even parity, extended mode, threshold of one byte
    task automatic test_rx();
        bus_wr(`SPUART_OFF_CFG, 32'h0000_04bb);
        u_remote.send({1'b1, 1'b1, 8'h5a, 1'b0});
        check(rx_thresh, 1'b1);
        bus_rd(`SPUART_OFF_RXDATA);
        check(d, 32'h0000_215a);
        bus_rd(`SPUART_OFF_STATUS);
        check(d, 32'h0);
        u_remote.send({1'b0, 1'b0, 8'h5a, 1'b0});
        bus_rd(`SPUART_OFF_RXDATA);
        check(d, 32'h0000_115a);
        u_remote.send(11'h000);
        bus_rd(`SPUART_OFF_RXDATA);
        check(d, 32'h0000_1900);
        bus_rd(`SPUART_OFF_RXDATA);
        check(d, 32'h0);
        $display("rx test done");
    endtask : test_rx
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        sys_nrst = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (16) @(posedge sys_clk);
        sys_nrst <= 1'b1;
        @(posedge sys_clk);
        test_reset();
        test_tx();
        test_rx();
        test_done();
    end
endmodule : test_serial_port_rx_status_uart
